/* File: hw/lsff_map.vh */
`ifndef LSFF_MAP_VH
`define LSFF_MAP_VH

// ----------------------------------------------------------------
// Management bus addressing
// ----------------------------------------------------------------
`define LSFF_DEV_ADDR       7'h50
`define LSFF_PTR_RESET      8'h00

// ----------------------------------------------------------------
// Lower page byte offsets
// ----------------------------------------------------------------
`define LSFF_OFS_STATUS_RSV  8'h01
`define LSFF_OFS_STATUS     8'h02
`define LSFF_OFS_LOS        8'h03
`define LSFF_OFS_TX_FAULT   8'h04
`define LSFF_OFS_FLAG_RSV_A 8'h05
`define LSFF_OFS_TEMP       8'h06
`define LSFF_OFS_VCC        8'h07
`define LSFF_OFS_FLAG_RSV_B 8'h08
`define LSFF_OFS_RXP_CH12   8'h09
`define LSFF_OFS_RXP_CH34   8'h0A
`define LSFF_OFS_BIAS_CH12  8'h0B
`define LSFF_OFS_BIAS_CH34  8'h0C
`define LSFF_OFS_TXP_CH12   8'h0D
`define LSFF_OFS_FLAG_LAST  8'h15

// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define LSFF_STS_NOT_READY  0
`define LSFF_STS_ATTN       1

// ----------------------------------------------------------------
// Flag bytes: bits that can ever be set
// ----------------------------------------------------------------
`define LSFF_MASK_LOS       8'h0F
`define LSFF_MASK_TX_FAULT  8'h0F
`define LSFF_MASK_MODULE    8'hF0
`define LSFF_MASK_CHANNEL   8'hFF
`define LSFF_MASK_TXP       8'hC0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LSFF_FLAG_RESET     8'h00
`define LSFF_NOT_READY_RST  1'b1
`define LSFF_ATTN_RESET     1'b1

`endif

/* File: hw/lsff_sync.v */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Two-flop synchroniser for the three pin inputs
// ----------------------------------------------------------------
module lsff_sync (
   input  wire       ref_clk,   // Core clock
   input  wire       rst_n,     // Async reset, active low
   input  wire [2:0] pin_in,    // Raw pins, idle high
   output wire [2:0] pin_sync   // Synchronised pins
);

   reg  [2:0] meta_reg;          // First stage, read by second only
   reg  [2:0] sync_reg;          // Second stage

   // ----------------------------------------------------------------
   // One chain per pin; idle-high reset avoids a false start
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_bit
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_reg[i] <= 1'b1;
               sync_reg[i] <= 1'b1;
            end else begin
               meta_reg[i] <= pin_in[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

   assign pin_sync = sync_reg;

endmodule // lsff_sync

/* File: hw/lsff_top.v */
`timescale 1ns/10ps
`include "lsff_map.vh"
module lsff_top (
   input  wire        ref_clk,          // Core clock, 100 MHz
   input  wire        rst_n,            // Async power-on reset, active low
   input  wire        module_reset_n,   // Module reset pin, active low
   input  wire        scl_in,           // Serial bus clock pin
   input  wire        sda_in,           // Serial bus data pin, level seen
   output wire        sda_out,          // Serial bus data driven value
   output wire        sda_oe,           // Serial bus data drive enable
   output wire        attention_out_n,  // Attention pin, active low
   input  wire        monitor_data_ready, // Monitor data now valid
   input  wire [3:0]  rx_los_cond,      // Receive signal loss, ch4..ch1
   input  wire [3:0]  tx_fault_cond,    // Transmit fault, ch4..ch1
   input  wire [3:0]  temp_cond,        // Temp HA, LA, HW, LW
   input  wire [3:0]  vcc_cond,         // Supply HA, LA, HW, LW
   input  wire [15:0] rx_power_cond,    // Rx power, ch1 at [15:12]
   input  wire [15:0] tx_bias_cond,     // Tx bias, ch1 at [15:12]
   input  wire [1:0]  tx_power_cond     // Tx power ch1 HA, LA
);

   // ----------------------------------------------------------------
   // Bus engine states
   // ----------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'd0;   // Waiting for a start
   localparam [2:0] ST_ADDR  = 3'd1;   // Receiving device address
   localparam [2:0] ST_AACK  = 3'd2;   // Acknowledging address
   localparam [2:0] ST_WR    = 3'd3;   // Receiving a written byte
   localparam [2:0] ST_WACK  = 3'd4;   // Acknowledging a written byte
   localparam [2:0] ST_RD    = 3'd5;   // Sending a byte
   localparam [2:0] ST_RACK  = 3'd6;   // Host acknowledge slot

   localparam NSLOT = 9;               // Flag bytes held here

   // Slot byte addresses, slot 0 in the low byte
   localparam [71:0] SLOT_ADDR = {`LSFF_OFS_TXP_CH12, `LSFF_OFS_BIAS_CH34,
                                  `LSFF_OFS_BIAS_CH12, `LSFF_OFS_RXP_CH34,
                                  `LSFF_OFS_RXP_CH12, `LSFF_OFS_VCC,
                                  `LSFF_OFS_TEMP, `LSFF_OFS_TX_FAULT,
                                  `LSFF_OFS_LOS};

   // Bits each slot may ever set; all others read zero
   localparam [71:0] SLOT_MASK = {`LSFF_MASK_TXP, `LSFF_MASK_CHANNEL,
                                  `LSFF_MASK_CHANNEL, `LSFF_MASK_CHANNEL,
                                  `LSFF_MASK_CHANNEL, `LSFF_MASK_MODULE,
                                  `LSFF_MASK_MODULE, `LSFF_MASK_TX_FAULT,
                                  `LSFF_MASK_LOS};

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire [2:0]  pin_sync;               // Synchronised scl, sda, reset
   wire        scl_s;                  // Synchronised serial clock
   wire        sda_s;                  // Synchronised serial data
   wire        mrst_s;                 // Synchronised module reset
   reg         scl_d_reg;              // Previous serial clock
   reg         sda_d_reg;              // Previous serial data
   wire        scl_rise;               // Serial clock rising
   wire        scl_fall;               // Serial clock falling
   wire        bus_start;              // Start condition seen
   wire        bus_stop;               // Stop condition seen

   reg  [2:0]  state_reg;              // Bus engine state
   reg  [3:0]  bit_cnt_reg;            // Bits moved in this byte
   reg  [7:0]  shift_reg;              // Receive shift register
   reg  [7:0]  tx_reg;                 // Transmit shift register
   reg  [7:0]  ptr_reg;                // Byte pointer
   reg         rw_reg;                 // Transfer is a read
   reg         first_reg;              // Next written byte is pointer
   reg         host_ack_reg;           // Host acked last read byte
   reg         sda_oe_reg;             // Drive data low
   reg  [7:0]  snap_addr_reg;          // Address of byte in flight
   reg  [7:0]  snap_bits_reg;          // Flag bits returned in flight
   reg         clr_reg;                // Clear pulse after a read byte

   reg  [71:0] flag_reg;               // Latched flags, all slots
   wire [71:0] cond_all;               // Raw conditions, all slots
   reg         not_ready_reg;          // Monitor data not yet valid
   reg         attn_n_reg;             // Attention pin driver
   reg  [7:0]  rd_data;                // Byte at a given pointer
   reg  [7:0]  rd_ptr;                 // Pointer fed to the read mux
   reg  [7:0]  next_ptr;               // Pointer after the current one
   integer     k;                      // Read mux loop index

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   lsff_sync u_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .pin_in   ({module_reset_n, sda_in, scl_in}),
      .pin_sync (pin_sync)
   );

   assign scl_s  = pin_sync[0];
   assign sda_s  = pin_sync[1];
   assign mrst_s = pin_sync[2];

   // ----------------------------------------------------------------
   // Edge and framing detection
   // ----------------------------------------------------------------
   // Delay line behind the synchronised pins
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_d_reg;
   assign scl_fall  = ~scl_s & scl_d_reg;
   // Data moving while clock high marks frame boundaries
   assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ----------------------------------------------------------------
   // Condition packing into byte slots
   // ----------------------------------------------------------------
   // Upper nibble of byte 3 is tied off: transmit loss unsupported
   assign cond_all = {tx_power_cond, 6'h00,
                      tx_bias_cond[7:0],
                      tx_bias_cond[15:8],
                      rx_power_cond[7:0],
                      rx_power_cond[15:8],
                      vcc_cond, 4'h0,
                      temp_cond, 4'h0,
                      4'h0, tx_fault_cond,
                      4'h0, rx_los_cond};

   // ----------------------------------------------------------------
   // Latched flag slots
   // ----------------------------------------------------------------
   // Only bits actually returned by a read are cleared, so an event
   // arriving mid-read, or in the clear cycle itself, survives.
   genvar s;
   generate
      for (s = 0; s < NSLOT; s = s + 1) begin : g_slot
         wire       hit;                 // Clear aimed at this slot
         wire [7:0] clr_bits;            // Bits to drop this cycle
         assign hit      = clr_reg & (snap_addr_reg == SLOT_ADDR[8*s +: 8]);
         assign clr_bits = hit ? snap_bits_reg : 8'h00;
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               flag_reg[8*s +: 8] <= `LSFF_FLAG_RESET;
            end else if (!mrst_s) begin
               flag_reg[8*s +: 8] <= `LSFF_FLAG_RESET;
            end else begin
               // Set beats clear; reserved bits never latch
               flag_reg[8*s +: 8] <= ((flag_reg[8*s +: 8] & ~clr_bits)
                                     | cond_all[8*s +: 8])
                                     & SLOT_MASK[8*s +: 8];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Status bits and attention output
   // ----------------------------------------------------------------
   // Not-ready stays high through module reset, drops on valid data
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         not_ready_reg <= `LSFF_NOT_READY_RST;
         attn_n_reg    <= `LSFF_ATTN_RESET;
      end else begin
         if (!mrst_s) begin
            not_ready_reg <= `LSFF_NOT_READY_RST;
         end else if (monitor_data_ready) begin
            not_ready_reg <= 1'b0;
         end
         attn_n_reg <= ~(|flag_reg);
      end
   end

   assign attention_out_n = attn_n_reg;

   // ----------------------------------------------------------------
   // Read mux over the lower page
   // ----------------------------------------------------------------
   // Bytes outside this block, and reserved ones, read zero
   always @* begin
      rd_data = 8'h00;
      if (rd_ptr == `LSFF_OFS_STATUS) begin
         rd_data[`LSFF_STS_NOT_READY] = not_ready_reg;
         rd_data[`LSFF_STS_ATTN]      = attn_n_reg;
      end
      // Field 3..21: slots present, gaps reserved
      for (k = 0; k < NSLOT; k = k + 1) begin
         if (rd_ptr == SLOT_ADDR[8*k +: 8]) begin
            rd_data = flag_reg[8*k +: 8];
         end
      end
   end

   // Pointer choice: the next byte once the current one is done
   always @* begin
      next_ptr = ptr_reg + 8'h01;
      if (state_reg == ST_RACK) begin
         rd_ptr = ptr_reg;
      end else begin
         rd_ptr = ptr_reg;
      end
   end

   // ----------------------------------------------------------------
   // Serial bus engine
   // ----------------------------------------------------------------
   // Open-drain data: value is always low, enable chooses to pull.
   // Everything runs on sampled edges, so the bus clock must stay
   // well below a quarter of the core clock.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= ST_IDLE;
         bit_cnt_reg   <= 4'h0;
         shift_reg     <= 8'h00;
         tx_reg        <= 8'h00;
         ptr_reg       <= `LSFF_PTR_RESET;
         rw_reg        <= 1'b0;
         first_reg     <= 1'b0;
         host_ack_reg  <= 1'b0;
         sda_oe_reg    <= 1'b0;
         snap_addr_reg <= 8'h00;
         snap_bits_reg <= 8'h00;
         clr_reg       <= 1'b0;
      end else begin
         clr_reg <= 1'b0;
         if (bus_start) begin
            // Repeated start keeps the pointer
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
         end else if (bus_stop) begin
            state_reg  <= ST_IDLE;
            sda_oe_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_ADDR: begin
                  if (scl_rise) begin
                     shift_reg   <= {shift_reg[6:0], sda_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     // Other addresses belong to someone else
                     if (shift_reg[7:1] == `LSFF_DEV_ADDR) begin
                        rw_reg     <= shift_reg[0];
                        sda_oe_reg <= 1'b1;
                        state_reg  <= ST_AACK;
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end
               end
               ST_AACK: begin
                  if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (rw_reg) begin
                        // Capture byte and the bits this read owns
                        tx_reg        <= rd_data;
                        snap_addr_reg <= ptr_reg;
                        snap_bits_reg <= rd_data;
                        sda_oe_reg    <= ~rd_data[7];
                        state_reg     <= ST_RD;
                     end else begin
                        first_reg  <= 1'b1;
                        sda_oe_reg <= 1'b0;
                        state_reg  <= ST_WR;
                     end
                  end
               end
               ST_WR: begin
                  if (scl_rise) begin
                     shift_reg   <= {shift_reg[6:0], sda_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     sda_oe_reg <= 1'b1;
                     state_reg  <= ST_WACK;
                     if (first_reg) begin
                        ptr_reg   <= shift_reg;
                        first_reg <= 1'b0;
                     end else begin
                        // Nothing here is writable: acked, dropped
                        ptr_reg <= next_ptr;
                     end
                  end
               end
               ST_WACK: begin
                  if (scl_fall) begin
                     sda_oe_reg  <= 1'b0;
                     bit_cnt_reg <= 4'h0;
                     state_reg   <= ST_WR;
                  end
               end
               ST_RD: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg == 4'h7) begin
                        // Whole byte out: now the flags may drop
                        sda_oe_reg <= 1'b0;
                        clr_reg    <= 1'b1;
                        ptr_reg    <= next_ptr;
                        state_reg  <= ST_RACK;
                     end else begin
                        tx_reg      <= {tx_reg[6:0], 1'b0};
                        sda_oe_reg  <= ~tx_reg[6];
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     host_ack_reg <= ~sda_s;
                  end else if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (host_ack_reg) begin
                        // Sequential read of the next byte
                        tx_reg        <= rd_data;
                        snap_addr_reg <= ptr_reg;
                        snap_bits_reg <= rd_data;
                        sda_oe_reg    <= ~rd_data[7];
                        state_reg     <= ST_RD;
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  state_reg  <= ST_IDLE;
                  sda_oe_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   assign sda_oe  = sda_oe_reg;
   assign sda_out = 1'b0;

endmodule // lsff_top

/* File: verif/latched_status_flag_field_test.sv */
`timescale 1ns/10ps
module latched_status_flag_field_test;
   logic        ref_clk = 1'b0;             // Core clock
   logic        rst_n = 1'b0;               // Async reset
   logic        module_reset_n = 1'b1;      // Module reset pin
   logic        monitor_data_ready = 1'b0;  // Monitor data valid
   logic [3:0]  rx_los_cond = '0, tx_fault_cond = '0, temp_cond = '0, vcc_cond = '0;
   logic [15:0] rx_power_cond = '0, tx_bias_cond = '0;
   logic [1:0]  tx_power_cond = '0;
   wire         scl, pull, sda_oe, sda_out, attention_out_n;
   wire         sda_in = ~pull & (~sda_oe | sda_out);  // Open drain, pulled up
   int          n_mismatch = 0, n_checks = 0, cycles = 0;
   logic [35:0] rows [14];                  // Select, pattern, byte, expected
   logic [7:0]  d, re [13];
   logic        nak;
   lsff_top u_dut (.ref_clk, .rst_n, .module_reset_n, .scl_in(scl), .sda_in, .sda_out,
      .sda_oe, .attention_out_n, .monitor_data_ready, .rx_los_cond, .tx_fault_cond,
      .temp_cond, .vcc_cond, .rx_power_cond, .tx_bias_cond, .tx_power_cond);
   lsff_host u_host (.scl, .pull, .sda(sda_in));
   always #5 ref_clk = ~ref_clk;
   // Hang guard, well above the roughly 16000 cycles needed
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         summarize;
      end
   end
   task automatic chk(input logic [7:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Frames start just after a core edge, so pins never move on it
   task automatic rd(input logic [7:0] a, exp);
      @(posedge ref_clk) #1;
      u_host.access(1'b0, a, 8'h00, d, nak);
      chk({7'h00, nak}, 8'h00);
      chk(d, exp);
   endtask
   task automatic conds(input logic v);
      {rx_los_cond, tx_fault_cond, temp_cond, vcc_cond, rx_power_cond, tx_bias_cond,
       tx_power_cond} = {50{v}};
   endtask
   // One-cycle condition pulse on the selected input
   task automatic pulse(input logic [3:0] s, input logic [15:0] p);
      @(posedge ref_clk) #1;
      case (s)
         0: rx_los_cond = p[3:0];
         1: tx_fault_cond = p[3:0];
         2: temp_cond = p[3:0];
         3: vcc_cond = p[3:0];
         4: rx_power_cond = p;
         5: tx_bias_cond = p;
         default: tx_power_cond = p[1:0];
      endcase
      @(posedge ref_clk) #1 conds(1'b0);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      rows = '{36'h0_0001_03_01, 36'h0_000F_03_0F, 36'h1_0004_04_04,
               36'h2_0008_06_80, 36'h2_0001_06_10, 36'h3_0002_07_20,
               36'h4_8000_09_80, 36'h4_0100_09_01, 36'h4_0001_0A_01,
               36'h4_0040_0A_40, 36'h5_4000_0B_40, 36'h5_0020_0C_20,
               36'h6_0002_0D_80, 36'h6_0001_0D_40};
      re = '{8'h00, 8'h00, 8'h0F, 8'h0F, 8'h00, 8'hF0, 8'hF0, 8'h00,
             8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC0};
      repeat (2) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(8'h02, 8'h03);
      @(posedge ref_clk) #1 monitor_data_ready = 1'b1;
      @(posedge ref_clk) #1 monitor_data_ready = 1'b0;
      rd(8'h02, 8'h02);
      $display("status test done");
      // Table: each bit lands in its byte, holds, then a read clears it
      foreach (rows[i]) begin
         pulse(rows[i][35:32], rows[i][31:16]);
         repeat (20) @(posedge ref_clk);
         chk({7'h00, attention_out_n}, 8'h00);
         rd(rows[i][15:8], rows[i][7:0]);
         rd(rows[i][15:8], 8'h00);
         chk({7'h00, attention_out_n}, 8'h01);
      end
      $display("flag table test done");
      // Everything at once, reserved write, then clear the field by reads
      @(posedge ref_clk) #1 conds(1'b1);
      repeat (4) @(posedge ref_clk);
      #1 conds(1'b0);
      u_host.access(1'b1, 8'h05, 8'hFF, d, nak);
      foreach (re[i]) rd(8'(i + 1), re[i]);
      chk({7'h00, attention_out_n}, 8'h01);
      $display("field test done");
      // Module reset clears flags and ignores conditions meanwhile
      pulse(4'h0, 16'h0002);
      @(posedge ref_clk) #1 module_reset_n = 1'b0;
      repeat (5) @(posedge ref_clk);
      pulse(4'h1, 16'h000F);
      repeat (6) @(posedge ref_clk);
      #1 chk({7'h00, attention_out_n}, 8'h01);
      module_reset_n = 1'b1;
      repeat (5) @(posedge ref_clk);
      rd(8'h03, 8'h00);
      rd(8'h04, 8'h00);
      rd(8'h02, 8'h03);
      $display("module reset test done");
      summarize;
   end
endmodule // latched_status_flag_field_test

/* File: verif/lsff_chk_sva.sv */
`timescale 1ns/10ps
// --------------------------------
// Port checker for the flag block
// --------------------------------
module lsff_chk (
   input logic        ref_clk,         // Core clock
   input logic        rst_n,           // Async reset
   input logic        module_reset_n,  // Module reset pin
   input logic        scl_in,          // Bus clock pin
   input logic        sda_oe,          // Device pulls data
   input logic        attention_out_n, // Attention pin
   input logic [3:0]  rx_los_cond,     // Signal loss
   input logic [3:0]  tx_fault_cond,   // Transmit fault
   input logic [3:0]  temp_cond,       // Temperature
   input logic [3:0]  vcc_cond,        // Supply
   input logic [15:0] rx_power_cond,   // Receive power
   input logic [15:0] tx_bias_cond,    // Transmit bias
   input logic [1:0]  tx_power_cond    // Transmit power
);
   // Any condition that asks for a flag
   wire any_c = |{rx_los_cond, tx_fault_cond, temp_cond, vcc_cond, rx_power_cond,
                  tx_bias_cond, tx_power_cond};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_reset_idle: assert property ($rose(rst_n) |-> attention_out_n && !sda_oe)
      else $error("outputs busy after reset");
   a_quiet_no_attn: assert property (attention_out_n && !$past(any_c) |=> attention_out_n)
      else $error("attention without a condition");
   a_cond_sets_attn: assert property (module_reset_n [*6] ##0 any_c |-> ##[1:3] !attention_out_n)
      else $error("condition did not raise attention");
   a_fall_has_cause: assert property ($fell(attention_out_n) |-> $past(any_c, 2))
      else $error("attention fell with no cause");
   // Clock standing high cannot clear anything, so the latch must hold
   a_latch_holds: assert property ((scl_in && module_reset_n && !attention_out_n) [*5]
      |=> !attention_out_n)
      else $error("flag lost without a read");
   a_mreset_clears: assert property (!module_reset_n [*6] |-> attention_out_n)
      else $error("module reset left a flag set");
   a_idle_release: assert property (scl_in [*8] |-> !sda_oe)
      else $error("data driven on an idle bus");
   a_oe_on_low_clk: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data changed while clock high");
   c_attn: cover property ($fell(attention_out_n));
   c_ack: cover property ($rose(sda_oe));
   c_mreset: cover property (!module_reset_n [*6]);
endmodule // lsff_chk
bind lsff_top lsff_chk u_chk (.ref_clk, .rst_n, .module_reset_n, .scl_in, .sda_oe,
   .attention_out_n, .rx_los_cond, .tx_fault_cond, .temp_cond, .vcc_cond, .rx_power_cond,
   .tx_bias_cond, .tx_power_cond);

/* File: verif/lsff_host.sv */
`timescale 1ns/10ps
`include "lsff_map.vh"
// --------------------------------
// Host on the two-wire bus
// --------------------------------
module lsff_host (
   output logic scl,   // Bus clock, idles high
   output logic pull,  // Host pulls data low
   input  logic sda    // Resolved data level
);
   initial {scl, pull} = 2'b10;
   // Data set while clock low, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      pull = ~b;
      #40 scl = 1'b1;
      #20 r = sda;
      #20 scl = 1'b0;
   endtask
   // Start or repeated start
   task automatic start;
      pull = 1'b0;
      #40 scl = 1'b1;
      #40 pull = 1'b1;
      #40 scl = 1'b0;
   endtask
   // Stop, then a short idle gap on the bus
   task automatic stop;
      pull = 1'b1;
      #40 scl = 1'b1;
      #40 pull = 1'b0;
      #43;
   endtask
   // MSB first; ninth bit released, so it ends a read
   task automatic xfer(input logic [7:0] w, output logic [7:0] r, output logic nak);
      for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
      bit_io(1'b1, nak);
   endtask
   // Pointer write, then one data byte or a one-byte read
   task automatic access(input logic wr, input logic [7:0] a, w,
                         output logic [7:0] d, output logic nak);
      logic [3:0] n;
      start;
      xfer({`LSFF_DEV_ADDR, 1'b0}, d, n[0]);
      xfer(a, d, n[1]);
      if (wr) begin
         xfer(w, d, n[2]);
      end else begin
         start;
         xfer({`LSFF_DEV_ADDR, 1'b1}, d, n[2]);
         xfer(8'hFF, d, n[3]);
      end
      stop;
      nak = |n[2:0];
   endtask
endmodule // lsff_host
